// ===== core/analog_ctrl.v
/*
 analog_ctrl: APB register file driving the audio DAC, reference DAC,
 two op-amps and bandgap of the analog front end.
 Byte offsets: audio control 0x00, audio low 0x04, audio high 0x08,
 reference control 0x0c, reference low 0x10, reference high 0x14,
 amplifier one 0x18, amplifier two 0x1c, bandgap 0x20. Any other
 address answers with pslverr and zero data and drops the write.
 Each register is one byte in pwdata[7:0]; upper bytes are ignored.
 Also holds masked_reg, one byte register, and amp_ctrl, the per
 amplifier output stage, both used only here.
 Assumes an APB master on clk; analog macros sit on the outputs.
*/
`timescale 1ns/1ns
`include "analog_ctrl_defs.vh"

module analog_ctrl (
	input  wire        clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg  [11:0] audio_sample,
	output reg  [2:0]  volume_level,
	output reg         audio_conv_enable,
	output reg         audio_out_valid,
	output reg  [9:0]  ref_conv_data,
	output reg         ref_conv_enable,
	output reg  [1:0]  ref_conv_reference,
	output wire        amp_one_mode_sel,
	output wire        amp_one_ref_sel,
	output wire        amp_one_enable,
	output wire [4:0]  amp_one_offset_trim,
	output wire        amp_one_cancel_switch_a,
	output wire        amp_one_cancel_switch_b,
	output wire        amp_one_to_adc_ch4_6,
	output wire        amp_two_mode_sel,
	output wire        amp_two_ref_sel,
	output wire        amp_two_enable,
	output wire [4:0]  amp_two_offset_trim,
	output wire        amp_two_cancel_switch_a,
	output wire        amp_two_cancel_switch_b,
	output wire        amp_two_to_adc_ch7,
	output reg         bandgap_enable,
	output reg  [1:0]  bandgap_out_select
);

	wire [7:0] audio_dac_control;
	wire [7:0] audio_sample_low;
	wire [7:0] audio_sample_high;
	wire [7:0] ref_dac_control;
	wire [7:0] ref_dac_data_low;
	wire [7:0] ref_dac_data_high;
	wire [7:0] amplifier_one_control;
	wire [7:0] amplifier_two_control;
	wire [7:0] bandgap_control;

	reg  [7:0] next_rdata;
	reg        hit;
	wire       setup = psel & ~penable;
	wire       wr_go = psel & penable & pready & pwrite;
	wire [7:0] wbyte = pwdata[7:0];

	// decode once; read data is latched in setup so access completes in one
	always @* begin
		hit = 1'b1;
		next_rdata = 8'h00;
		case (paddr)
		`OFS_AUDIO_CTRL: next_rdata = audio_dac_control;
		`OFS_AUDIO_LOW:  next_rdata = audio_sample_low;
		`OFS_AUDIO_HIGH: next_rdata = audio_sample_high;
		`OFS_REF_CTRL:   next_rdata = ref_dac_control;
		`OFS_REF_LOW:    next_rdata = ref_dac_data_low;
		`OFS_REF_HIGH:   next_rdata = ref_dac_data_high;
		`OFS_AMP_ONE:    next_rdata = amplifier_one_control;
		`OFS_AMP_TWO:    next_rdata = amplifier_two_control;
		`OFS_BANDGAP:    next_rdata = bandgap_control;
		default:         hit = 1'b0;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata  <= {24'h000000, next_rdata};
				pslverr <= ~hit;
			end else if (pready) begin
				pslverr <= 1'b0;
			end
		end
	end

	// one strobe per register, only at the completing access edge
	wire       ld_audio_ctrl = wr_go & (paddr == `OFS_AUDIO_CTRL);
	wire       ld_audio_low  = wr_go & (paddr == `OFS_AUDIO_LOW);
	wire       ld_audio_high = wr_go & (paddr == `OFS_AUDIO_HIGH);
	wire       ld_ref_ctrl   = wr_go & (paddr == `OFS_REF_CTRL);
	wire       ld_ref_low    = wr_go & (paddr == `OFS_REF_LOW);
	wire       ld_ref_high   = wr_go & (paddr == `OFS_REF_HIGH);
	wire       ld_amp_one    = wr_go & (paddr == `OFS_AMP_ONE);
	wire       ld_amp_two    = wr_go & (paddr == `OFS_AMP_TWO);
	wire       ld_bandgap    = wr_go & (paddr == `OFS_BANDGAP);

	// low bytes carry their bits left-justified
	wire [3:0] audio_low_bits = audio_sample_low[`AUDL_MSB:`AUDL_LSB];
	wire [1:0] ref_low_bits   = ref_dac_data_low[`REFL_MSB:`REFL_LSB];

	// masks keep unimplemented positions at zero whatever is written
	masked_reg #(
		.MASK      (`MASK_AUDIO_CTRL),
		.RESET_VAL (`REG_RESET)
	) audio_ctrl_q (
		.clk  (clk),
		.rst  (rst),
		.load (ld_audio_ctrl),
		.din  (wbyte),
		.q    (audio_dac_control)
	);

	masked_reg #(
		.MASK      (`MASK_AUDIO_LOW),
		.RESET_VAL (`REG_RESET)
	) audio_low_q (
		.clk  (clk),
		.rst  (rst),
		.load (ld_audio_low),
		.din  (wbyte),
		.q    (audio_sample_low)
	);

	masked_reg #(
		.MASK      (`MASK_AUDIO_HIGH),
		.RESET_VAL (`REG_RESET)
	) audio_high_q (
		.clk  (clk),
		.rst  (rst),
		.load (ld_audio_high),
		.din  (wbyte),
		.q    (audio_sample_high)
	);

	masked_reg #(
		.MASK      (`MASK_REF_CTRL),
		.RESET_VAL (`REG_RESET)
	) ref_ctrl_q (
		.clk  (clk),
		.rst  (rst),
		.load (ld_ref_ctrl),
		.din  (wbyte),
		.q    (ref_dac_control)
	);

	masked_reg #(
		.MASK      (`MASK_REF_LOW),
		.RESET_VAL (`REG_RESET)
	) ref_low_q (
		.clk  (clk),
		.rst  (rst),
		.load (ld_ref_low),
		.din  (wbyte),
		.q    (ref_dac_data_low)
	);

	masked_reg #(
		.MASK      (`MASK_REF_HIGH),
		.RESET_VAL (`REG_RESET)
	) ref_high_q (
		.clk  (clk),
		.rst  (rst),
		.load (ld_ref_high),
		.din  (wbyte),
		.q    (ref_dac_data_high)
	);

	masked_reg #(
		.MASK      (`MASK_AMP),
		.RESET_VAL (`REG_RESET)
	) amp_one_q (
		.clk  (clk),
		.rst  (rst),
		.load (ld_amp_one),
		.din  (wbyte),
		.q    (amplifier_one_control)
	);

	masked_reg #(
		.MASK      (`MASK_AMP),
		.RESET_VAL (`REG_RESET)
	) amp_two_q (
		.clk  (clk),
		.rst  (rst),
		.load (ld_amp_two),
		.din  (wbyte),
		.q    (amplifier_two_control)
	);

	masked_reg #(
		.MASK      (`MASK_BANDGAP),
		.RESET_VAL (`REG_RESET)
	) bandgap_q (
		.clk  (clk),
		.rst  (rst),
		.load (ld_bandgap),
		.din  (wbyte),
		.q    (bandgap_control)
	);

	// analog controls lag the register by one cycle so all outputs are flops
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			audio_sample      <= `SAMPLE_RESET;
			volume_level      <= `VOL_RESET;
			audio_conv_enable <= `BIT_RESET;
			audio_out_valid   <= `BIT_RESET;
		end else begin
			// sample is zeroed while off so nothing stale reaches the pin
			if (audio_dac_control[`EN_BIT])
				audio_sample <= {audio_sample_high,
					audio_low_bits};
			else
				audio_sample <= `SAMPLE_RESET;
			volume_level <= audio_dac_control[`VOL_MSB:`VOL_LSB];
			audio_conv_enable <= audio_dac_control[`EN_BIT];
			audio_out_valid <= audio_dac_control[`EN_BIT];
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_conv_data      <= `REF_DATA_RESET;
			ref_conv_enable    <= `BIT_RESET;
			ref_conv_reference <= `SEL_RESET;
		end else begin
			ref_conv_data <= {ref_dac_data_high,
				ref_low_bits};
			ref_conv_enable <= ref_dac_control[`EN_BIT];
			// floating select only matters if the bandgap is running
			ref_conv_reference <=
				bandgap_control[`BG_SEL_MSB:`BG_SEL_LSB];
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			bandgap_enable     <= `BIT_RESET;
			bandgap_out_select <= `SEL_RESET;
		end else begin
			bandgap_enable <= bandgap_control[`BG_EN_BIT];
			bandgap_out_select <=
				bandgap_control[`BG_SEL_MSB:`BG_SEL_LSB];
		end
	end

	// each amplifier has its own output stage; only the register and the feed differ
	amp_ctrl amp_one_i (
		.clk             (clk),
		.rst             (rst),
		.ctrl            (amplifier_one_control),
		.mode_sel        (amp_one_mode_sel),
		.ref_sel         (amp_one_ref_sel),
		.enable          (amp_one_enable),
		.offset_trim     (amp_one_offset_trim),
		.cancel_switch_a (amp_one_cancel_switch_a),
		.cancel_switch_b (amp_one_cancel_switch_b),
		.to_adc          (amp_one_to_adc_ch4_6)
	);

	amp_ctrl amp_two_i (
		.clk             (clk),
		.rst             (rst),
		.ctrl            (amplifier_two_control),
		.mode_sel        (amp_two_mode_sel),
		.ref_sel         (amp_two_ref_sel),
		.enable          (amp_two_enable),
		.offset_trim     (amp_two_offset_trim),
		.cancel_switch_a (amp_two_cancel_switch_a),
		.cancel_switch_b (amp_two_cancel_switch_b),
		.to_adc          (amp_two_to_adc_ch7)
	);

endmodule // analog_ctrl

// one byte of control state; positions outside MASK never leave zero
module masked_reg #(
	parameter             WIDTH     = 8,
	parameter [WIDTH-1:0] MASK      = {WIDTH{1'b1}},
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             load,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] q
);

	// masking on load, not on read, so the read mux needs no mask
	always @(posedge clk or posedge rst) begin
		if (rst)
			q <= RESET_VAL;
		else if (load)
			q <= din & MASK;
	end

endmodule // masked_reg

// one amplifier's control fields, each pin driven from its own flop
// so the analog side never sees a decode glitch
module amp_ctrl (
	input  wire       clk,
	input  wire       rst,
	input  wire [7:0] ctrl,
	output reg        mode_sel,
	output reg        ref_sel,
	output reg        enable,
	output reg  [4:0] offset_trim,
	output reg        cancel_switch_a,
	output reg        cancel_switch_b,
	output reg        to_adc
);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			// switches open in reset and close one edge after release
			mode_sel        <= `BIT_RESET;
			ref_sel         <= `BIT_RESET;
			enable          <= `BIT_RESET;
			offset_trim     <= `TRIM_RESET;
			cancel_switch_a <= `BIT_RESET;
			cancel_switch_b <= `BIT_RESET;
			to_adc          <= `BIT_RESET;
		end else begin
			mode_sel        <= ctrl[`AMP_MODE_BIT];
			ref_sel         <= ctrl[`AMP_REF_BIT];
			enable          <= ctrl[`AMP_EN_BIT];
			offset_trim     <= ctrl[`TRIM_MSB:`TRIM_LSB];
			// mode zero closes both cancellation switches together
			cancel_switch_a <= ~ctrl[`AMP_MODE_BIT];
			cancel_switch_b <= ~ctrl[`AMP_MODE_BIT];
			// a disabled amplifier feeds nothing to the converter
			to_adc          <= ctrl[`AMP_EN_BIT];
		end
	end

endmodule // amp_ctrl

// ===== shared/analog_ctrl_defs.vh
/*
 analog_ctrl_defs.vh: register offsets, field positions and reset values
 for the analog helper control block. Assumes a byte-address APB map.
*/
`ifndef ANALOG_CTRL_DEFS_VH
`define ANALOG_CTRL_DEFS_VH

`define OFS_AUDIO_CTRL    12'h000
`define OFS_AUDIO_LOW     12'h004
`define OFS_AUDIO_HIGH    12'h008
`define OFS_REF_CTRL      12'h00c
`define OFS_REF_LOW       12'h010
`define OFS_REF_HIGH      12'h014
`define OFS_AMP_ONE       12'h018
`define OFS_AMP_TWO       12'h01c
`define OFS_BANDGAP       12'h020

`define MASK_AUDIO_CTRL   8'he1
`define MASK_AUDIO_LOW    8'hf0
`define MASK_AUDIO_HIGH   8'hff
`define MASK_REF_CTRL     8'h01
`define MASK_REF_LOW      8'hc0
`define MASK_REF_HIGH     8'hff
`define MASK_AMP          8'hff
`define MASK_BANDGAP      8'h13

`define REG_RESET         8'h00

`define VOL_MSB           7
`define VOL_LSB           5
`define EN_BIT            0
`define AMP_MODE_BIT      7
`define AMP_REF_BIT       6
`define AMP_EN_BIT        5
`define TRIM_MSB          4
`define TRIM_LSB          0
`define BG_EN_BIT         4
`define BG_SEL_MSB        1
`define BG_SEL_LSB        0
`define AUDL_MSB          7
`define AUDL_LSB          4
`define REFL_MSB          7
`define REFL_LSB          6

`define SAMPLE_RESET      12'h000
`define REF_DATA_RESET    10'h000
`define VOL_RESET         3'h0
`define SEL_RESET         2'h0
`define TRIM_RESET        5'h00
`define BIT_RESET         1'b0

`define BG_SEL_SUPPLY     2'b10
`define BG_SEL_FLOAT      2'b11

`endif

// ===== sim/analog_ctrl_sva.sv
/* analog_ctrl_sva: port checks for analog_ctrl.
 Assumes binding into analog_ctrl and the defs header on the path. */
`timescale 1ns/1ns
`include "analog_ctrl_defs.vh"
module analog_ctrl_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [11:0] audio_sample,
	input wire logic        audio_conv_enable,
	input wire logic        amp_one_mode_sel,
	input wire logic        amp_one_enable,
	input wire logic [4:0]  amp_one_offset_trim,
	input wire logic        amp_one_cancel_switch_a,
	input wire logic        amp_one_cancel_switch_b,
	input wire logic        amp_one_to_adc_ch4_6,
	input wire logic [1:0]  ref_conv_reference,
	input wire logic [1:0]  bandgap_out_select
);
	logic [4:0] wd;
	// held per completed access, read or write, so the two-cycle check sees the written trim
	always @(posedge clk) begin
		if (psel && penable && pready)
			wd <= pwdata[4:0];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_amp_wr;
		psel && penable && pready && pwrite && paddr == `OFS_AMP_ONE;
	endsequence
	property p_ready; psel && !penable |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
	property p_mute; !audio_conv_enable |-> audio_sample == 12'h0; endproperty
	property p_sw; !$past(rst) |-> amp_one_cancel_switch_a ==
		!amp_one_mode_sel && amp_one_cancel_switch_b == !amp_one_mode_sel;
	endproperty
	property p_ref; ref_conv_reference == bandgap_out_select; endproperty
	property p_ch; amp_one_to_adc_ch4_6 == amp_one_enable; endproperty
	property p_trim; s_amp_wr |-> ##2 amp_one_offset_trim == wd; endproperty
	property p_err; pready && paddr == 12'h024 |-> pslverr && prdata == 0;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	a_pulse: assert property (p_pulse) else $error("ready too long");
	a_hi: assert property (p_hi) else $error("upper read bits set");
	a_mute: assert property (p_mute) else $error("audio not muted");
	a_sw: assert property (p_sw) else $error("switch mismatch");
	a_ref: assert property (p_ref) else $error("reference wrong");
	a_ch: assert property (p_ch) else $error("channel feed wrong");
	a_trim: assert property (p_trim) else $error("trim wrong");
	a_err: assert property (p_err) else $error("no slave error");
endmodule // analog_ctrl_sva
bind analog_ctrl analog_ctrl_sva analog_ctrl_sva_i (.*);

// ===== sim/analog_ctrl_tb.sv
/* analog_ctrl_tb: register and output checks of analog_ctrl.
 Assumes design and checker compile first. */
`timescale 1ns/1ns
`include "analog_ctrl_defs.vh"
module analog_ctrl_tb;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0, audio_sample;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, audio_conv_enable, audio_out_valid, er;
	logic [2:0]  volume_level;
	logic [9:0]  ref_conv_data;
	logic [1:0]  ref_conv_reference, bandgap_out_select;
	logic        ref_conv_enable, bandgap_enable;
	logic        amp_one_mode_sel, amp_one_ref_sel, amp_one_enable;
	logic        amp_one_cancel_switch_a, amp_one_cancel_switch_b;
	logic        amp_one_to_adc_ch4_6, amp_two_to_adc_ch7;
	logic        amp_two_mode_sel, amp_two_ref_sel, amp_two_enable;
	logic        amp_two_cancel_switch_a, amp_two_cancel_switch_b;
	logic [4:0]  amp_one_offset_trim, amp_two_offset_trim;
	logic [7:0]  wd [10] = '{8'hff, 8'hff, 8'ha5, 8'hff, 8'hff, 8'h3c,
		8'h75, 8'hd3, 8'hff, 8'h5a};
	logic [7:0]  ex [10] = '{8'he1, 8'hf0, 8'ha5, 8'h01, 8'hc0, 8'h3c,
		8'h75, 8'hd3, 8'h13, 8'h00};
	int          n_mismatch = 0, n_checks = 0;
	analog_ctrl analog_ctrl_i (.*);
	initial begin
		forever #50 clk = ~clk;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %0t got %h want %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20) begin
			n_mismatch++;
			results;
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 10; i++) begin
			apb(0, 12'(i * 4), 8'h00);
			chk(rd, 0);
		end
		// rows: write, read back masked value, error only on last
		for (int i = 0; i < 10; i++) begin
			apb(1, 12'(i * 4), wd[i]);
			apb(0, 12'(i * 4), 8'h00);
			chk(rd, ex[i]);
			chk(er, i == 9);
		end
		@(negedge clk);
		chk({audio_sample, volume_level, audio_conv_enable}, 16'ha5ff);
		chk(audio_out_valid, 1);
		chk({ref_conv_data, ref_conv_enable}, {10'h0f3, 1'b1});
		chk({amp_one_mode_sel, amp_one_ref_sel, amp_one_enable,
			amp_one_offset_trim}, 8'h75);
		chk({amp_two_mode_sel, amp_two_ref_sel, amp_two_enable,
			amp_two_offset_trim}, 8'hd3);
		chk({amp_one_cancel_switch_a, amp_one_cancel_switch_b,
			amp_two_cancel_switch_a, amp_two_cancel_switch_b}, 4'hc);
		chk({amp_one_to_adc_ch4_6, amp_two_to_adc_ch7}, 2'b10);
		chk({bandgap_enable, bandgap_out_select}, 3'h7);
		apb(1, `OFS_AUDIO_CTRL, 8'h40);
		repeat (2) @(negedge clk);
		chk({audio_sample, volume_level, audio_conv_enable}, 16'h0004);
		chk(audio_out_valid, 0);
		for (int s = 0; s < 4; s++) begin
			apb(1, `OFS_BANDGAP, 8'(s));
			repeat (2) @(negedge clk);
			chk({ref_conv_reference, bandgap_enable}, {2'(s), 1'b0});
			chk(bandgap_out_select, s);
		end
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		apb(0, `OFS_AMP_ONE, 8'h00);
		chk(rd, 0);
		results;
	end
endmodule // analog_ctrl_tb
